// ---- src/eac_params.svh ----
// Constants for the EEPROM access control block
`ifndef EAC_PARAMS_SVH
`define EAC_PARAMS_SVH

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define EAC_CTRL_READ_BIT   0
`define EAC_CTRL_WRITE_BIT  1
`define EAC_CTRL_MWE_BIT    2
`define EAC_CTRL_RIE_BIT    3
`define EAC_CTRL_RESET      8'h00

// ----------------------------------------------------------------------
// Address and data
// ----------------------------------------------------------------------
`define EAC_ADDR_W          9
`define EAC_DEPTH           512
`define EAC_ADDR_RESET      9'h000
`define EAC_DATA_RESET      8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define EAC_MWE_WINDOW      3'h4
`define EAC_WRITE_STALL     3'h2
`define EAC_READ_STALL      3'h4
`define EAC_RC_FREQ_KHZ     1000
`define EAC_WRITE_TIME_US   8500
`define EAC_WRITE_RC_CYCLES 8448

`endif

// ---- src/eac_pkg.sv ----
// Types shared by the EEPROM access control modules
package eac_pkg;

  typedef enum logic [1:0] {
    sel_control,
    sel_addr_lo,
    sel_addr_hi,
    sel_data
  } eac_sel_t;

  typedef enum logic {
    st_idle,
    st_program
  } eac_wr_state_t;

endpackage

// ---- src/eac_core_if.sv ----
// Link between the register front end and the programming core
interface eac_core_if;
  logic       start;
  logic [8:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       busy;

  modport ctl  (output start, addr, wdata, input  rdata, busy);
  modport core (input  start, addr, wdata, output rdata, busy);
endinterface

// ---- src/eac_core.sv ----
// Self-timed EEPROM array and programming sequencer
`include "eac_params.svh"

module eac_core
  import eac_pkg::*;
#(
  parameter int WRITE_RC_CYCLES = `EAC_WRITE_RC_CYCLES
) (
  input  wire logic  ref_clk,
  input  wire logic  por_n,
  input  wire logic  rc_osc_clk,
  eac_core_if.core   bus
);

  logic [7:0]     mem [`EAC_DEPTH];
  eac_wr_state_t  state_ff;
  logic [8:0]     wr_addr_ff;
  logic [7:0]     wr_data_ff;
  logic [13:0]    rc_cnt_ff;
  logic           rc_meta_ff;
  logic           rc_sync_ff;
  logic           rc_prev_ff;
  logic           rc_tick;
  logic           done;

  // ----------------------------------------------------------------------
  // Calibrated oscillator sampled into the system clock
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      rc_meta_ff <= 1'b0;
      rc_sync_ff <= 1'b0;
      rc_prev_ff <= 1'b0;
    end else begin
      rc_meta_ff <= rc_osc_clk;
      rc_sync_ff <= rc_meta_ff;
      rc_prev_ff <= rc_sync_ff;
    end
  end

  assign rc_tick = rc_sync_ff && !rc_prev_ff;
  assign done    = rc_tick && (rc_cnt_ff == 14'(WRITE_RC_CYCLES - 1));

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Only power-on clears it, so a system reset leaves a write running
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      state_ff  <= st_idle;
      rc_cnt_ff <= 14'h0000;
    end else begin
      unique case (state_ff)
        st_idle: begin
          rc_cnt_ff <= 14'h0000;
          if (bus.start) begin
            state_ff <= st_program;
          end
        end
        st_program: begin
          if (done) begin
            state_ff <= st_idle;
          end else if (rc_tick) begin
            rc_cnt_ff <= rc_cnt_ff + 14'h0001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      wr_addr_ff <= `EAC_ADDR_RESET;
      wr_data_ff <= `EAC_DATA_RESET;
    end else if (bus.start && state_ff == st_idle) begin
      wr_addr_ff <= bus.addr;
      wr_data_ff <= bus.wdata;
    end
  end

  // Nonvolatile cells: no reset
  always_ff @(posedge ref_clk) begin
    if (state_ff == st_program && done) begin
      mem[wr_addr_ff] <= wr_data_ff;
    end
  end

  assign bus.rdata = mem[bus.addr];
  assign bus.busy  = (state_ff == st_program);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_write_duration: assert property (@(posedge ref_clk) disable iff (!por_n)
    $fell(bus.busy) |-> $past(rc_cnt_ff) == 14'(WRITE_RC_CYCLES - 1))
    else $error("write ended before the programming count elapsed");

endmodule

// ---- src/eac_top.sv ----
// Register front end of the data EEPROM access control block
//
// Function
// - Control bits 7..4 always read zero.
// - Ready enable and global enable give an interrupt while no write runs.
// - Write strobe starts a write only within four cycles of master enable.
// - Master enable clears itself four cycles after being set.
// - A started write programs the data byte at the selected address.
// - No write starts while flash self-programming is active.
// - Write strobe reads one while programming, then clears itself.
// - A started write stalls the CPU two cycles.
// - Read strobe loads the addressed byte into the data register at once.
// - A read stalls the CPU four cycles.
// - During a write reads are ignored and the address is frozen.
// - Writes last 8448 calibrated 1 MHz oscillator cycles.
// - Power-down during a write keeps the oscillator until it finishes.
// - Reset does not abort a write in progress.
// - Address holds nine bits; upper seven read zero.
// - Data register feeds writes and receives reads.
`include "eac_params.svh"

module eac_top
  import eac_pkg::*;
#(
  parameter int WRITE_RC_CYCLES = `EAC_WRITE_RC_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        por_n,
  input  wire logic        rc_osc_clk,
  input  wire logic        cpu_io_wr,
  input  wire eac_sel_t    cpu_io_sel,
  input  wire logic [7:0]  cpu_io_wdata,
  input  wire logic        global_irq_enable,
  input  wire logic        self_program_active,
  input  wire logic        sleep_power_down,
  output logic [7:0]       eeprom_control,
  output logic [15:0]      byte_address_reg,
  output logic [7:0]       byte_data_reg_ff,
  output logic             cpu_stall_ff,
  output logic             ready_irq_ff,
  output logic             main_osc_keep_ff,
  output logic             power_down_ok_ff
);

  eac_core_if bus ();

  logic       rie_ff;
  logic       mwe_ff;
  logic [2:0] mwe_cnt_ff;
  logic [8:0] addr_ff;
  logic [2:0] stall_cnt_ff;
  logic       ctl_wr;
  logic       wr_go;
  logic       rd_go;
  logic       addr_lo_wr;
  logic       addr_hi_wr;
  logic       data_wr;

  // ----------------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------------
  assign ctl_wr     = cpu_io_wr && (cpu_io_sel == sel_control);
  assign addr_lo_wr = cpu_io_wr && (cpu_io_sel == sel_addr_lo);
  assign addr_hi_wr = cpu_io_wr && (cpu_io_sel == sel_addr_hi);
  assign data_wr    = cpu_io_wr && (cpu_io_sel == sel_data);

  // Strobe honoured only inside the enable window, idle, flash quiet
  assign wr_go = ctl_wr && cpu_io_wdata[`EAC_CTRL_WRITE_BIT]
                 && mwe_ff && !bus.busy
                 && !self_program_active;

  // Write wins if both strobes arrive together
  assign rd_go = ctl_wr && cpu_io_wdata[`EAC_CTRL_READ_BIT]
                 && !bus.busy && !wr_go;

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rie_ff <= 1'b0;
    end else if (ctl_wr) begin
      rie_ff <= cpu_io_wdata[`EAC_CTRL_RIE_BIT];
    end
  end

  // Master enable times out after the window
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mwe_ff     <= 1'b0;
      mwe_cnt_ff <= 3'h0;
    end else if (ctl_wr && cpu_io_wdata[`EAC_CTRL_MWE_BIT]) begin
      mwe_ff     <= 1'b1;
      mwe_cnt_ff <= `EAC_MWE_WINDOW;
    end else if (ctl_wr) begin
      mwe_ff     <= 1'b0;
      mwe_cnt_ff <= 3'h0;
    end else if (mwe_cnt_ff != 3'h0) begin
      mwe_cnt_ff <= mwe_cnt_ff - 3'h1;
      if (mwe_cnt_ff == 3'h1) begin
        mwe_ff <= 1'b0;
      end
    end
  end

  // Read strobe is never stored, write strobe mirrors the busy core
  assign eeprom_control = {4'h0, rie_ff, mwe_ff, bus.busy, 1'b0};

  // ----------------------------------------------------------------------
  // Address and data registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_ff <= `EAC_ADDR_RESET;
    end else if (!bus.busy) begin
      if (addr_lo_wr) begin
        addr_ff[7:0] <= cpu_io_wdata;
      end else if (addr_hi_wr) begin
        addr_ff[8] <= cpu_io_wdata[0];
      end
    end
  end

  assign byte_address_reg = {7'h00, addr_ff};

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      byte_data_reg_ff <= `EAC_DATA_RESET;
    end else if (rd_go) begin
      byte_data_reg_ff <= bus.rdata;
    end else if (data_wr) begin
      byte_data_reg_ff <= cpu_io_wdata;
    end
  end

  assign bus.start = wr_go;
  assign bus.addr  = addr_ff;
  assign bus.wdata = byte_data_reg_ff;

  // ----------------------------------------------------------------------
  // CPU stall
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stall_cnt_ff <= 3'h0;
      cpu_stall_ff <= 1'b0;
    end else if (wr_go) begin
      stall_cnt_ff <= `EAC_WRITE_STALL;
      cpu_stall_ff <= 1'b1;
    end else if (rd_go) begin
      stall_cnt_ff <= `EAC_READ_STALL;
      cpu_stall_ff <= 1'b1;
    end else if (stall_cnt_ff != 3'h0) begin
      stall_cnt_ff <= stall_cnt_ff - 3'h1;
      cpu_stall_ff <= (stall_cnt_ff > 3'h1);
    end else begin
      cpu_stall_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt level and power-down interlock
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_irq_ff <= 1'b0;
    end else begin
      ready_irq_ff <= rie_ff && global_irq_enable && !bus.busy;
    end
  end

  // Main oscillator kept alive so the write can finish in sleep
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      main_osc_keep_ff <= 1'b0;
      power_down_ok_ff <= 1'b0;
    end else begin
      main_osc_keep_ff <= sleep_power_down && bus.busy;
      power_down_ok_ff <= sleep_power_down && !bus.busy;
    end
  end

  // ----------------------------------------------------------------------
  // Programming core
  // ----------------------------------------------------------------------
  eac_core #(
    .WRITE_RC_CYCLES (WRITE_RC_CYCLES)
  ) u_core (
    .ref_clk    (ref_clk),
    .por_n      (por_n),
    .rc_osc_clk (rc_osc_clk),
    .bus        (bus.core)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n || !por_n);

  a_reserved_bits_zero: assert property (
    eeprom_control[7:4] == 4'h0 && eeprom_control[0] == 1'b0)
    else $error("reserved or read strobe bits read nonzero");

  a_irq_ready_level: assert property (
    rie_ff && global_irq_enable && !bus.busy |=> ready_irq_ff)
    else $error("ready interrupt missing while idle");

  a_irq_busy_quiet: assert property (
    bus.busy |=> !ready_irq_ff)
    else $error("ready interrupt raised during a write");

  a_start_needs_mwe: assert property (
    $rose(bus.busy) |-> $past(mwe_ff) && $past(ctl_wr))
    else $error("write started without master enable");

  a_mwe_timeout: assert property (
    (ctl_wr && cpu_io_wdata[`EAC_CTRL_MWE_BIT]) ##1 (!ctl_wr) [*4]
    |=> !mwe_ff)
    else $error("master enable did not time out after four cycles");

  a_mwe_window: assert property (
    (ctl_wr && cpu_io_wdata[`EAC_CTRL_MWE_BIT]) ##1 (!ctl_wr) [*3]
    |-> mwe_ff)
    else $error("master enable cleared inside its window");

  a_flash_lock: assert property (
    self_program_active && !bus.busy |=> !bus.busy)
    else $error("write started during flash self-programming");

  a_write_busy: assert property (
    wr_go |=> bus.busy [*8])
    else $error("write strobe not held during programming");

  a_write_stall: assert property (
    wr_go |=> cpu_stall_ff [*2] ##1 !cpu_stall_ff)
    else $error("write stall not two cycles");

  a_read_stall: assert property (
    rd_go |=> cpu_stall_ff [*4] ##1 !cpu_stall_ff)
    else $error("read stall not four cycles");

  a_read_data_load: assert property (
    rd_go |=> byte_data_reg_ff == $past(bus.rdata))
    else $error("read did not load the addressed byte");

  a_addr_frozen: assert property (
    bus.busy && (addr_lo_wr || addr_hi_wr) |=> $stable(addr_ff))
    else $error("address changed during a write");

  a_read_ignored: assert property (
    bus.busy && !data_wr |=> $stable(byte_data_reg_ff))
    else $error("data register changed by a read during a write");

  // Sampled reset_n skips the edge on which reset lets go
  a_osc_kept: assert property (
    reset_n && sleep_power_down && bus.busy
    |=> main_osc_keep_ff && !power_down_ok_ff)
    else $error("oscillator released during a write in power-down");

  a_osc_released: assert property (
    !bus.busy |=> !main_osc_keep_ff)
    else $error("oscillator held with no write running");

  a_pd_ok_idle: assert property (
    reset_n && sleep_power_down && !bus.busy |=> power_down_ok_ff)
    else $error("power-down refused while idle");

  a_mwe_last_cycle: assert property (
    (ctl_wr && cpu_io_wdata[`EAC_CTRL_MWE_BIT]) ##1 (!ctl_wr) [*3]
    ##1 (ctl_wr && cpu_io_wdata[`EAC_CTRL_WRITE_BIT] && !bus.busy
         && !self_program_active)
    |=> bus.busy)
    else $error("write strobe refused in the last enable cycle");

  a_no_mwe_start: assert property (
    ctl_wr && cpu_io_wdata[`EAC_CTRL_WRITE_BIT] && !mwe_ff && !bus.busy
    |=> !bus.busy)
    else $error("write started without master enable set");

  a_stall_cause: assert property (
    $rose(cpu_stall_ff) |-> $past(wr_go || rd_go))
    else $error("CPU stalled with no access started");

  a_addr_low_load: assert property (
    addr_lo_wr && !bus.busy |=> addr_ff[7:0] == $past(cpu_io_wdata))
    else $error("address low byte not loaded");

  a_data_load: assert property (
    data_wr |=> byte_data_reg_ff == $past(cpu_io_wdata))
    else $error("data register not loaded by a write");

  a_rie_load: assert property (
    ctl_wr |=> rie_ff == $past(cpu_io_wdata[`EAC_CTRL_RIE_BIT]))
    else $error("ready interrupt enable not loaded");

  c_read_done: cover property (rd_go ##5 !cpu_stall_ff);
  c_write_start: cover property (wr_go ##1 bus.busy);
  c_mwe_expired: cover property ($fell(mwe_ff) && !ctl_wr);
  c_irq_raised: cover property ($rose(ready_irq_ff));
  c_sleep_write: cover property (sleep_power_down && bus.busy
                                 ##1 main_osc_keep_ff);

endmodule

// ---- bench/eac_cpu_model.sv ----
// CPU core model issuing I/O register writes to the EEPROM block
module eac_cpu_model
  import eac_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  cpu_stall_ff,
  input  wire logic  busy,
  input  wire logic  spm_busy,
  output logic       cpu_io_wr,
  output eac_sel_t   cpu_io_sel,
  output logic [7:0] cpu_io_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cpu_io_wr = 1'b0;
    cpu_io_sel = sel_control;
    cpu_io_wdata = 8'h00;
  end

  // A halted core issues nothing; idle data is inverted, not held
  task automatic io_write(input eac_sel_t s, input logic [7:0] d);
    @(posedge ref_clk);
    while (cpu_stall_ff !== 1'b0) @(posedge ref_clk);
    cpu_io_wr <= 1'b1;
    cpu_io_sel <= s;
    cpu_io_wdata <= d;
    @(posedge ref_clk);
    cpu_io_wr <= 1'b0;
    cpu_io_wdata <= ~d;
  endtask

  task automatic set_addr(input logic [8:0] a);
    while (busy !== 1'b0) @(posedge ref_clk);
    io_write(sel_addr_lo, a[7:0]);
    io_write(sel_addr_hi, {7'h00, a[8]});
  endtask

  task automatic write_byte(input logic [8:0] a, input logic [7:0] d,
                            input logic [7:0] x);
    while (spm_busy !== 1'b0) @(posedge ref_clk);
    set_addr(a);
    io_write(sel_data, d);
    io_write(sel_control, x | 8'h04);
    io_write(sel_control, x | 8'h02);
  endtask

  task automatic read_byte(input logic [8:0] a);
    set_addr(a);
    io_write(sel_control, 8'h01);
  endtask
endmodule

// ---- bench/tb_eac_top.sv ----
// Self-checking testbench for the EEPROM access control block
module tb_eac_top
  import eac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [8:0]  a;
    logic [7:0]  d;
    logic [15:0] e;
  } eac_tb_row_t;

  logic        ref_clk = 1'b0;
  logic        rc_osc_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        por_n = 1'b0;
  logic        gie = 1'b0;
  logic        spm = 1'b0;
  logic        sleep = 1'b0;
  logic        wr;
  eac_sel_t    sel;
  logic [7:0]  wdata;
  logic [7:0]  ctl;
  logic [15:0] addr_q;
  logic [7:0]  data_q;
  logic        stall;
  logic        irq;
  logic        osc_keep;
  logic        pd_ok;
  int          bad_count = 0;
  int          checks = 0;
  int          cycles = 0;
  int          n;
  eac_tb_row_t rows [3] = '{'{9'h000, 8'hA5, 16'h0000},
                            '{9'h1FF, 8'h5A, 16'h01FF},
                            '{9'h0FF, 8'h3C, 16'h00FF}};

  always #20 ref_clk = ~ref_clk;
  // Odd start offset keeps the oscillator out of phase with ref_clk
  initial begin
    #137;
    forever #500 rc_osc_clk = ~rc_osc_clk;
  end

  eac_top #(.WRITE_RC_CYCLES(8)) DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .por_n(por_n),
    .rc_osc_clk(rc_osc_clk), .cpu_io_wr(wr), .cpu_io_sel(sel),
    .cpu_io_wdata(wdata), .global_irq_enable(gie),
    .self_program_active(spm), .sleep_power_down(sleep),
    .eeprom_control(ctl), .byte_address_reg(addr_q),
    .byte_data_reg_ff(data_q), .cpu_stall_ff(stall),
    .ready_irq_ff(irq), .main_osc_keep_ff(osc_keep),
    .power_down_ok_ff(pd_ok));

  eac_cpu_model cpu (
    .ref_clk(ref_clk), .cpu_stall_ff(stall), .busy(ctl[1]),
    .spm_busy(spm), .cpu_io_wr(wr), .cpu_io_sel(sel),
    .cpu_io_wdata(wdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic edges(int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  task automatic count_stall(output int c);
    #1;
    c = 0;
    while (stall === 1'b1 && c < 10) begin
      c++;
      edges(1);
    end
  endtask

  task automatic wait_idle(output int k);
    k = 0;
    while (ctl[1] !== 1'b0 && k < 2000) begin
      k++;
      edges(1);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Budget is several times the expected run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      stop_test;
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    por_n <= 1'b1;
    #1;
    chk("ctl_rst", 16'(ctl), 16'h0000);
    chk("addr_rst", addr_q, 16'h0000);
    chk("data_rst", 16'(data_q), 16'h0000);
    $display("test reset done");
    foreach (rows[i]) begin
      cpu.write_byte(rows[i].a, rows[i].d, 8'h00);
      count_stall(n);
      chk("wr_stall", 16'(n), 16'h0002);
      chk("busy", 16'(ctl[1]), 16'h0001);
      wait_idle(n);
      chk("wr_time", 16'(n >= 170 && n <= 230), 16'h0001);
      cpu.read_byte(rows[i].a);
      count_stall(n);
      chk("rd_stall", 16'(n), 16'h0004);
      chk("rd_data", 16'(data_q), 16'(rows[i].d));
      chk("addr", addr_q, rows[i].e);
      chk("ctl_idle", 16'(ctl), 16'h0000);
    end
    $display("test table done");
    cpu.io_write(sel_control, 8'hFC);
    #1;
    chk("resv", 16'(ctl), 16'h000C);
    edges(6);
    chk("mwe_clr", 16'(ctl), 16'h0008);
    chk("irq_off", 16'(irq), 16'h0000);
    @(posedge ref_clk);
    gie <= 1'b1;
    edges(2);
    chk("irq_on", 16'(irq), 16'h0001);
    cpu.io_write(sel_control, 8'h04);
    edges(5);
    cpu.io_write(sel_control, 8'h02);
    edges(2);
    chk("late", 16'(ctl[1]), 16'h0000);
    cpu.io_write(sel_control, 8'h04);
    edges(2);
    cpu.io_write(sel_control, 8'h02);
    edges(1);
    chk("edge", 16'(ctl[1]), 16'h0001);
    wait_idle(n);
    @(posedge ref_clk);
    spm <= 1'b1;
    cpu.io_write(sel_control, 8'h04);
    cpu.io_write(sel_control, 8'h02);
    edges(2);
    chk("spm", 16'(ctl[1]), 16'h0000);
    $display("test refusals done");
    @(posedge ref_clk);
    spm <= 1'b0;
    sleep <= 1'b1;
    gie <= 1'b0;
    cpu.write_byte(9'h055, 8'hC3, 8'h08);
    count_stall(n);
    @(posedge ref_clk);
    gie <= 1'b1;
    edges(2);
    chk("irq_busy", 16'(irq), 16'h0000);
    chk("osc_keep", 16'(osc_keep), 16'h0001);
    chk("pd_busy", 16'(pd_ok), 16'h0000);
    cpu.io_write(sel_addr_lo, 8'hAA);
    cpu.io_write(sel_control, 8'h09);
    edges(2);
    chk("addr_frz", addr_q, 16'h0055);
    chk("rd_ign", 16'(data_q), 16'h00C3);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    chk("rst_busy", 16'(ctl[1]), 16'h0001);
    wait_idle(n);
    edges(2);
    chk("pd_idle", 16'(pd_ok), 16'h0001);
    @(posedge ref_clk);
    sleep <= 1'b0;
    cpu.read_byte(9'h055);
    #1;
    chk("rst_data", 16'(data_q), 16'h00C3);
    $display("test busy done");
    stop_test;
  end
endmodule
